/* include/sdc_pkg.sv */
package sdc_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h10;
    localparam int MODE_HI = 13;
    localparam int MODE_LO = 12;
    localparam int CODE_HI = 11;
    localparam int CODE_LO = 4;
    localparam int CODE_W = 8;
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;

    // ----------------------------------------------------------------
    // Wake-up timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WAKE_NS = 2500;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_W = 9;

    // Operating modes selected by the two mode bits of a frame
    typedef enum logic [1:0] {
        SDC_NORMAL = 2'b00,
        SDC_PD_1K = 2'b01,
        SDC_PD_100K = 2'b10,
        SDC_PD_HIZ = 2'b11
    } sdc_mode_t;

    // Synchronised link pins
    typedef struct packed {
        logic sync_n;
        logic sclk;
        logic din;
    } sdc_link_t;

    // Output stage controls
    typedef struct packed {
        logic amp_on;
        logic term_1k;
        logic term_100k;
        logic out_valid;
    } sdc_outctl_t;

endpackage

/* src/sdc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_sync
    import sdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire sdc_link_t pin_in,
    output sdc_link_t pin_out
);
    // Two-stage synchroniser; first stage feeds only the second
    typedef struct packed {
        sdc_link_t s1;
        sdc_link_t s2;
    } sdc_sync_st_t;

    sdc_sync_st_t st_r;
    sdc_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.s1 = pin_in;
            st_nxt.s2 = st_r.s1;
        end
    end

    // Idle level: frame sync high, clock low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{s1: 3'b100, s2: 3'b100};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.s2;
endmodule // sdc_sync
`default_nettype wire

/* src/sdc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic din,
    output logic [CODE_W-1:0] dac_code,
    output sdc_mode_t dac_mode,
    output logic amp_on,
    output logic term_1k,
    output logic term_100k,
    output logic out_valid,
    output logic frame_done,
    output logic frame_abort
);
    // ----------------------------------------------------------------
    // Types and state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SDC_IDLE = 2'b00,
        SDC_SHIFT = 2'b01,
        SDC_DONE = 2'b10
    } sdc_state_t;

    typedef struct packed {
        sdc_state_t fsm;
        logic sync_d;
        logic sclk_d;
        logic [FRAME_BITS-1:0] shreg;
        logic [CNT_W-1:0] cnt;
        logic [CODE_W-1:0] code;
        sdc_mode_t mode;
        logic [WAKE_W-1:0] wake;
        sdc_outctl_t oc;
        logic done;
        logic abort;
    } sdc_st_t;

    sdc_st_t st_r;
    sdc_st_t st_nxt;
    sdc_link_t pins;
    logic sync_fall;
    logic sync_rise;
    logic sclk_fall;

    // Output stage decode for a mode, applied on every enabled cycle; reset loads its normal-mode value directly
    function automatic sdc_outctl_t sdc_outctl(input sdc_mode_t m, input logic ready);
        sdc_outctl_t o;
        o.amp_on = (m == SDC_NORMAL);
        o.term_1k = (m == SDC_PD_1K);
        o.term_100k = (m == SDC_PD_100K);
        o.out_valid = (m == SDC_NORMAL) && ready;
        return o;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    sdc_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in({sync_n, sclk, din}),
        .pin_out(pins)
    );

    // Edge detection on synchronised copies only
    assign sync_fall = st_r.sync_d && !pins.sync_n;
    assign sync_rise = !st_r.sync_d && pins.sync_n;
    assign sclk_fall = st_r.sclk_d && !pins.sclk;

    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.sync_d = pins.sync_n;
            st_nxt.sclk_d = pins.sclk;
            st_nxt.done = 1'b0;
            st_nxt.abort = 1'b0;
            // Wake-up countdown; output only valid once it expires
            if (st_r.wake != '0) begin
                st_nxt.wake = st_r.wake - 1'b1;
            end
            st_nxt.oc = sdc_outctl(st_r.mode, st_r.wake == '0);
            unique case (st_r.fsm)
                SDC_IDLE: begin
                    // Only a fresh fall arms the register
                    if (sync_fall) begin
                        st_nxt.fsm = SDC_SHIFT;
                        st_nxt.shreg = '0;
                        st_nxt.cnt = '0;
                    end
                end
                SDC_SHIFT: begin
                    if (sync_rise) begin
                        // Early rise discards, code and mode untouched
                        st_nxt.fsm = SDC_IDLE;
                        st_nxt.shreg = '0;
                        st_nxt.cnt = '0;
                        st_nxt.abort = 1'b1;
                    end else if (sclk_fall) begin
                        // MSB first: shift toward the top
                        st_nxt.shreg = {st_r.shreg[FRAME_BITS-2:0], pins.din};
                        st_nxt.cnt = st_r.cnt + 1'b1;
                        if (st_r.cnt == FRAME_LAST - 1'b1) begin
                            st_nxt.fsm = SDC_DONE;
                            st_nxt.done = 1'b1;
                            st_nxt.code = st_r.shreg[CODE_HI-1:CODE_LO-1];
                            st_nxt.mode = sdc_mode_t'(st_r.shreg[MODE_HI-1:MODE_LO-1]);
                            // Code register loads on every frame; a return to normal restarts the wake-up count
                            if (st_r.mode != SDC_NORMAL &&
                                st_r.shreg[MODE_HI-1:MODE_LO-1] == 2'b00) begin
                                st_nxt.wake = WAKE_W'(WAKE_CYCLES);
                            end
                        end
                    end
                end
                SDC_DONE: begin
                    // Further clock edges are ignored until sync rises
                    if (pins.sync_n) begin
                        st_nxt.fsm = SDC_IDLE;
                    end
                end
                default: begin
                    st_nxt.fsm = SDC_IDLE;
                end
            endcase
        end
    end

    // Power-on: code zero, normal mode, output valid at 0 V
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{fsm: SDC_IDLE, sync_d: 1'b1, sclk_d: 1'b0, shreg: '0, cnt: '0,
                      code: CODE_RST, mode: SDC_NORMAL, wake: '0,
                      oc: 4'b1001, done: 1'b0, abort: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dac_code = st_r.code;
    assign dac_mode = st_r.mode;
    assign amp_on = st_r.oc.amp_on;
    assign term_1k = st_r.oc.term_1k;
    assign term_100k = st_r.oc.term_100k;
    assign out_valid = st_r.oc.out_valid;
    assign frame_done = st_r.done;
    assign frame_abort = st_r.abort;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_abort_keeps;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_abort |-> $stable(dac_code) && $stable(dac_mode);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed code or mode");

    property p_code_only_on_done;
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(dac_code) |-> frame_done;
    endproperty
    a_code_only_on_done: assert property (p_code_only_on_done) else $error("code changed without frame");

    property p_mode_held;
        @(posedge sys_clk) disable iff (!rst_n)
        !frame_done |-> $stable(dac_mode);
    endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode changed without frame");

    property p_done_after_16;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_done |-> $past(st_r.cnt) == FRAME_LAST - 1'b1;
    endproperty
    a_done_after_16: assert property (p_done_after_16) else $error("frame done without 16 edges");

    property p_no_restart_low;
        @(posedge sys_clk) disable iff (!rst_n)
        (st_r.fsm == SDC_DONE) && !pins.sync_n |=> st_r.fsm == SDC_DONE;
    endproperty
    a_no_restart_low: assert property (p_no_restart_low) else $error("frame restarted while low");

    property p_pd_term;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && $past(clk_en) && dac_mode == SDC_PD_1K && $stable(dac_mode)
            |-> term_1k && !amp_on && !term_100k;
    endproperty
    a_pd_term: assert property (p_pd_term) else $error("1k termination missing");

    sequence s_wake_start;
        frame_done && dac_mode == SDC_NORMAL && $past(dac_mode) != SDC_NORMAL;
    endsequence

    property p_wake_gap;
        @(posedge sys_clk) disable iff (!rst_n)
        s_wake_start |-> !out_valid [*2];
    endproperty
    a_wake_gap: assert property (p_wake_gap) else $error("output valid before wake-up");

    property p_pd_keeps_code;
        @(posedge sys_clk) disable iff (!rst_n)
        dac_mode != SDC_NORMAL |=> $stable(dac_code) || frame_done;
    endproperty
    a_pd_keeps_code: assert property (p_pd_keeps_code) else $error("code lost in power-down");

endmodule // sdc_ctrl
`default_nettype wire

/* bench/sdc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host serial port: polarity 0, phase 1, most significant bit first
// ----------------------------------------------------------------
module sdc_host (
    input wire logic sys_clk,
    output logic sync_n,
    output logic sclk,
    output logic din
);
    // Idle pins at time zero, link clock stands still between frames
    initial begin
        sync_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // One transfer; entered just after a falling sys_clk edge.
    // Data moves on the rising link clock so it is settled at the falling one.
    task automatic xfer(input logic [15:0] w, input int nfall, input bit arm, input int gap,
                        input bit drop);
        if (arm) begin
            sync_n = 1'b1;
            repeat (8) @(negedge sys_clk);
            sync_n = 1'b0;
            repeat (8) @(negedge sys_clk);
        end
        for (int i = 0; i < nfall; i++) begin
            sclk = 1'b1;
            din = (i < 16) ? w[15-i] : ~din;
            repeat (8) @(negedge sys_clk);
            sclk = 1'b0;
            repeat (8) @(negedge sys_clk);
            if (i == 7) repeat (gap) @(negedge sys_clk);
        end
        // Released data line must not keep its last value
        din = ~din;
        if (drop) sync_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule // sdc_host
`default_nettype wire

/* bench/serial_dac_control_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module serial_dac_control_port_tb_top
    import sdc_pkg::*;
;
    localparam int WAKE = 4;
    typedef struct packed {logic abort; logic wake; logic [7:0] code; sdc_mode_t mode;} sdc_note_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic sync_n, sclk, din, amp_on, term_1k, term_100k, out_valid, frame_done, frame_abort;
    logic [7:0] dac_code;
    sdc_mode_t dac_mode;
    int n_mismatch = 0;
    int checked = 0;
    sdc_note_t q[$];
    sdc_note_t cur;
    logic [31:0] rs = 32'h00017577;
    logic [7:0] ecode = 8'h00;
    sdc_mode_t emode = SDC_NORMAL;

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Design and host
    // ------------------------------------------------------------
    sdc_ctrl #(.WAKE_CYCLES(WAKE)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sync_n(sync_n), .sclk(sclk), .din(din), .dac_code(dac_code), .dac_mode(dac_mode),
        .amp_on(amp_on), .term_1k(term_1k), .term_100k(term_100k), .out_valid(out_valid),
        .frame_done(frame_done), .frame_abort(frame_abort));
    sdc_host host_u (.sys_clk(sys_clk), .sync_n(sync_n), .sclk(sclk), .din(din));

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Output stage expected for a mode; three-state drives nothing
    task automatic chk_out(input sdc_mode_t m);
        `CHK("amp_on", m == SDC_NORMAL, amp_on)
        `CHK("term_1k", m == SDC_PD_1K, term_1k)
        `CHK("term_100k", m == SDC_PD_100K, term_100k)
    endtask

    // Random frame; the note is queued before the wire sees it
    task automatic frame(input logic [1:0] m, input int nfall, input int gap, input bit drop);
        logic [15:0] w;
        sdc_note_t n;
        w = 16'(rnd());
        w[13:12] = m;
        n.abort = nfall < 16;
        n.wake = !n.abort && emode != SDC_NORMAL && m == 2'h0;
        if (!n.abort) begin
            ecode = w[11:4];
            emode = sdc_mode_t'(m);
        end
        n.code = ecode;
        n.mode = emode;
        q.push_back(n);
        host_u.xfer(w, nfall, 1'b1, gap, drop);
    endtask

    // ------------------------------------------------------------
    // Result watcher: each pulse takes the oldest note
    // ------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (rst_n && (frame_done === 1'b1 || frame_abort === 1'b1)) begin
            if (q.size() == 0) begin
                `CHK("stray pulse", 1'b0, 1'b1)
            end else begin
                cur = q.pop_front();
                `CHK("frame_abort", cur.abort, frame_abort)
                `CHK("dac_code", cur.code, dac_code)
                `CHK("dac_mode", cur.mode, dac_mode)
                @(negedge sys_clk);
                chk_out(cur.mode);
                `CHK("out_valid", cur.mode == SDC_NORMAL && !cur.wake, out_valid)
                if (cur.wake) begin
                    repeat (WAKE + 2) @(negedge sys_clk);
                    `CHK("out_valid", 1'b1, out_valid)
                end
            end
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        `CHK("dac_code", 8'h00, dac_code)
        `CHK("dac_mode", SDC_NORMAL, dac_mode)
        chk_out(SDC_NORMAL);
        `CHK("out_valid", 1'b1, out_valid)
        // Every mode, each followed by a return to normal operation
        for (int m = 0; m < 4; m++) begin
            frame(2'(m), 16, 0, 1'b1);
            frame(2'h0, 16, 0, 1'b1);
        end
        // Aborts one edge short of the last and early keep mode and code
        frame(2'h1, 16, 0, 1'b1);
        frame(2'h0, 15, 0, 1'b1);
        frame(2'h2, 3, 0, 1'b1);
        // Byte host with a pause, extra edges, sync left low, then bare clocks
        frame(2'h0, 20, 40, 1'b0);
        host_u.xfer(16'hFFFF, 16, 1'b0, 0, 1'b0);
        frame(2'h3, 16, 0, 1'b1);
        // Frozen clock enable: a whole frame goes unseen and no state moves
        clk_en = 1'b0;
        host_u.xfer(16'(rnd()), 16, 1'b1, 0, 1'b1);
        clk_en = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK("dac_code", ecode, dac_code)
        `CHK("dac_mode", emode, dac_mode)
        for (int k = 0; k < 100 && q.size() > 0; k++) @(negedge sys_clk);
        `CHK("pending notes", 0, q.size())
        repeat (20) @(negedge sys_clk);
        conclude();
    end
endmodule // serial_dac_control_port_tb_top
`default_nettype wire
